//--- verilog/pmrc_params.svh
// Constants for the power-mode and reset control block
`ifndef PMRC_PARAMS_SVH
`define PMRC_PARAMS_SVH
`define PMRC_MODE_SLEEP      2'h0
`define PMRC_MODE_DEEPSLEEP  2'h1
`define PMRC_MODE_POWERDOWN  2'h2
`define PMRC_MODE_DEEPPD     2'h3
`define PMRC_RST_PULSE_NS    50
`define PMRC_CLK_NS          25
`define PMRC_RST_STRETCH     4'h8
`define PMRC_RESET_VECTOR    32'h00000000
`define PMRC_RETAIN_COUNT    4
`endif

//--- verilog/pmrc_pkg.sv
// Types shared by the power-mode and reset control block
`default_nettype none
package pmrc_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_DEEPSLEEP, ST_POWERDOWN, ST_DEEPPD} pmode_e;
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic irc_run;
    logic irc_out_en;
    logic sysosc_en;
    logic watchdog_oscillator_en;
    logic bod_en;
    logic analog_en;
    logic flash_on;
    logic flash_standby;
    logic main_power_on;
  } power_gate_s;
  typedef struct packed {
    logic pin_int;
    logic wdt_int;
    logic usart_int;
    logic spi_int;
    logic i2c_int;
  } wake_src_s;
endpackage : pmrc_pkg
`default_nettype wire

//--- verilog/power_mode_reset_control.sv
// Power-mode sequencing, wake-up qualification, reset merging and brownout handling
// Notes on behaviour
// - Sleep stops core clock; wake re-enables it
// - Sleep halts core; peripherals run, interrupts wake
// - Deep-sleep stops peripheral clocks, gates RC output
// - Deep-sleep: analog off, flash standby
// - Deep-sleep wake: reset, pin, watchdog, serial slaves
// - Deep-sleep and power-down wake interrupt needs both enables set
// - Power-down: sources off, analog and flash off
// - Power-down wakes on same sources
// - Watchdog oscillator and brownout optionally kept on
// - Deep power-down keeps only wake pin, timer
// - Four retention registers survive deep power-down
// - Deep power-down exits on wake pin, timer
// - Lock bit refuses deep power-down entry
// - Chip reset merges pin, watchdog, power-on, brownout
// - Chip reset starts RC oscillator, flash init
// - Reset pin low 50 ns is caught
// - Core fetches from address zero after reset
// - Brownout below interrupt level raises interrupt
// - Brownout state readable as status
// - Brownout below reset level forces reset
// - RC oscillator runs until software selects other
// - PLL off and bypassed after reset
`include "pmrc_params.svh"
`default_nettype none
module power_mode_reset_control #(
  parameter int RETAIN_W = 32  // Width of each retention register
) (
  input  wire logic                   clk_sys,          // System clock, 40 MHz
  input  wire logic                   reset,            // Power-on reset, sync, active high
  input  wire logic                   reset_pin_n,      // External reset pin, active low
  input  wire logic                   wdt_reset,        // Watchdog reset request
  input  wire logic                   bod_below_int,    // Supply under selected interrupt level
  input  wire logic                   bod_below_rst,    // Supply under selected reset level
  input  wire logic                   bod_rst_en,       // Brownout reset enable
  input  wire logic                   sleep_req,        // Core sleep request, one-cycle pulse
  input  wire logic [1:0]             mode_sel,         // Selected reduced-power mode
  input  wire logic                   dpd_lock,         // Refuse deep power-down
  input  wire logic                   keep_watchdog_oscillator,       // Keep watchdog oscillator in deep-sleep and power-down
  input  wire logic                   keep_bod,         // Keep brownout detector in deep-sleep and power-down
  input  wire logic                   wake_pin_timer_en,  // Self wake-up timer enable
  input  wire logic                   wake_pin_timer_to,  // Self wake-up timer time-out
  input  wire logic                   wake_pin_n,       // Wake pin, active low
  input  wire logic                   any_irq,          // Pending enabled interrupt at the controller
  input  wire pmrc_pkg::wake_src_s    wake_int,         // Wake-capable interrupt lines
  input  wire pmrc_pkg::wake_src_s    wake_en_cfg,      // Wake enables of config block
  input  wire pmrc_pkg::wake_src_s    wake_en_ctl,      // Enables of interrupt controller
  input  wire logic                   clk_sel_write,    // Software clock source selection strobe
  input  wire logic                   pll_enable,       // Software PLL enable
  input  wire logic                   retain_we,        // Retention register write strobe
  input  wire logic [1:0]             retain_idx,       // Retention register index
  input  wire logic [RETAIN_W-1:0]    retain_wdata,     // Retention write data
  output logic [RETAIN_W-1:0]         retain_rdata,     // Retention read data
  output pmrc_pkg::power_gate_s       gates,            // Supply and clock gates
  output pmrc_pkg::pmode_e            mode_state,       // Current power mode
  output logic                        chip_reset,       // Merged chip reset
  output logic                        flash_init,       // Flash controller initialise pulse
  output logic [31:0]                 fetch_addr,       // Core start fetch address
  output logic                        irc_selected,     // Main clock taken from RC oscillator
  output logic                        pll_on,           // PLL powered
  output logic                        pll_bypass,       // PLL bypassed
  output logic                        bod_irq,          // Brownout interrupt request
  output logic                        bod_status,       // Brownout status for polling
  output logic                        dpd_refused       // Deep power-down entry refused pulse
);

  // ==========================================================================
  // Timing and checks
  localparam int RST_MIN_CYC = (`PMRC_RST_PULSE_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS;

  if (RETAIN_W < 1 || RST_MIN_CYC < 1) begin : g_bad_params
    $error("power_mode_reset_control: bad parameters");
  end

  // ==========================================================================
  // Input synchronisers
  logic [1:0] pin_sync_r;
  logic [1:0] wake_sync_r;
  logic [1:0] bodi_sync_r;
  logic [1:0] bodr_sync_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_sync_r  <= 2'h3;
      wake_sync_r <= 2'h3;
      bodi_sync_r <= 2'h0;
      bodr_sync_r <= 2'h0;
    end else begin
      pin_sync_r  <= {pin_sync_r[0], reset_pin_n};
      wake_sync_r <= {wake_sync_r[0], wake_pin_n};
      bodi_sync_r <= {bodi_sync_r[0], bod_below_int};
      bodr_sync_r <= {bodr_sync_r[0], bod_below_rst};
    end
  end

  wire logic pin_low  = ~pin_sync_r[1];
  wire logic wake_evt = ~wake_sync_r[1];
  wire logic bod_int  = bodi_sync_r[1];
  wire logic bod_rst  = bodr_sync_r[1];

  // ==========================================================================
  // Reset merging and stretch
  // A 50 ns low lasts two sampling periods, so a single low sample suffices
  logic       rst_src;
  logic [3:0] rst_cnt_r;
  logic       chip_reset_r;
  logic       chip_reset_d_r;

  assign rst_src = reset | pin_low | wdt_reset | (bod_rst & bod_rst_en);

  always_ff @(posedge clk_sys) begin
    if (rst_src) begin
      rst_cnt_r    <= `PMRC_RST_STRETCH;
      chip_reset_r <= 1'b1;
    end else if (rst_cnt_r != 4'h0) begin
      rst_cnt_r    <= rst_cnt_r - 4'h1;
      chip_reset_r <= 1'b1;
    end else begin
      chip_reset_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    chip_reset_d_r <= chip_reset_r;
  end

  assign chip_reset = chip_reset_r;
  assign flash_init = chip_reset_r & ~chip_reset_d_r;
  assign fetch_addr = `PMRC_RESET_VECTOR;

  // ==========================================================================
  // Clock source and PLL after reset
  logic irc_sel_r;
  logic pll_on_r;

  always_ff @(posedge clk_sys) begin
    if (chip_reset_r) begin
      irc_sel_r <= 1'b1;
    end else if (clk_sel_write) begin
      irc_sel_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (chip_reset_r) begin
      pll_on_r <= 1'b0;
    end else begin
      pll_on_r <= pll_enable;
    end
  end

  assign irc_selected = irc_sel_r;
  assign pll_on       = pll_on_r;
  assign pll_bypass   = ~pll_on_r;

  // ==========================================================================
  // Brownout interrupt and status
  logic bod_irq_r;

  always_ff @(posedge clk_sys) begin
    if (chip_reset_r) begin
      bod_irq_r <= 1'b0;
    end else begin
      bod_irq_r <= bod_int;
    end
  end

  assign bod_irq    = bod_irq_r;
  assign bod_status = bod_irq_r;

  // ==========================================================================
  // Wake qualification
  function automatic logic wake_hit(input pmrc_pkg::wake_src_s src, input pmrc_pkg::wake_src_s ena,
                                    input pmrc_pkg::wake_src_s enb);
    wake_hit = |(src & ena & enb);
  endfunction : wake_hit

  logic deep_wake;
  assign deep_wake = wake_hit(wake_int, wake_en_cfg, wake_en_ctl);

  // ==========================================================================
  // Mode state machine
  pmrc_pkg::pmode_e mode_r;
  pmrc_pkg::pmode_e mode_nxt;
  logic             refuse_nxt;
  logic             refuse_r;

  always_comb begin
    mode_nxt   = mode_r;
    refuse_nxt = 1'b0;
    case (mode_r)
      pmrc_pkg::ST_RUN: begin
        if (sleep_req) begin
          case (mode_sel)
            `PMRC_MODE_SLEEP:     mode_nxt = pmrc_pkg::ST_SLEEP;
            `PMRC_MODE_DEEPSLEEP: mode_nxt = pmrc_pkg::ST_DEEPSLEEP;
            `PMRC_MODE_POWERDOWN: mode_nxt = pmrc_pkg::ST_POWERDOWN;
            default: begin
              if (dpd_lock) begin
                refuse_nxt = 1'b1;
              end else begin
                mode_nxt = pmrc_pkg::ST_DEEPPD;
              end
            end
          endcase
        end
      end
      pmrc_pkg::ST_SLEEP: begin
        if (any_irq) begin
          mode_nxt = pmrc_pkg::ST_RUN;
        end
      end
      pmrc_pkg::ST_DEEPSLEEP,
      pmrc_pkg::ST_POWERDOWN: begin
        if (deep_wake) begin
          mode_nxt = pmrc_pkg::ST_RUN;
        end
      end
      pmrc_pkg::ST_DEEPPD: begin
        if (wake_evt || (wake_pin_timer_en && wake_pin_timer_to)) begin
          mode_nxt = pmrc_pkg::ST_RUN;
        end
      end
      default: mode_nxt = pmrc_pkg::ST_RUN;
    endcase
  end

  // Only wake pin or timer leave deep power-down; power-on reset still forces a known state
  always_ff @(posedge clk_sys) begin
    if (reset || (chip_reset_r && mode_r != pmrc_pkg::ST_DEEPPD)) begin
      mode_r   <= pmrc_pkg::ST_RUN;
      refuse_r <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      refuse_r <= refuse_nxt;
    end
  end

  assign mode_state  = mode_r;
  assign dpd_refused = refuse_r;

  // ==========================================================================
  // Supply and clock gating per mode
  always_comb begin
    gates = '{default: 1'b1};
    gates.flash_standby = 1'b0;
    gates.sysosc_en     = ~irc_sel_r;
    case (mode_r)
      pmrc_pkg::ST_SLEEP: begin
        gates.core_clk_en = 1'b0;
      end
      pmrc_pkg::ST_DEEPSLEEP: begin
        gates.core_clk_en   = 1'b0;
        gates.periph_clk_en = 1'b0;
        gates.irc_out_en    = 1'b0;
        gates.sysosc_en     = 1'b0;
        gates.watchdog_oscillator_en      = keep_watchdog_oscillator;
        gates.bod_en        = keep_bod;
        gates.analog_en     = 1'b0;
        gates.flash_on      = 1'b0;
        gates.flash_standby = 1'b1;
      end
      pmrc_pkg::ST_POWERDOWN: begin
        gates.core_clk_en   = 1'b0;
        gates.periph_clk_en = 1'b0;
        gates.irc_run       = 1'b0;
        gates.irc_out_en    = 1'b0;
        gates.sysosc_en     = 1'b0;
        gates.watchdog_oscillator_en      = keep_watchdog_oscillator;
        gates.bod_en        = keep_bod;
        gates.analog_en     = 1'b0;
        gates.flash_on      = 1'b0;
      end
      pmrc_pkg::ST_DEEPPD: begin
        gates = '{default: 1'b0};
      end
      default: begin
        gates.irc_run = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Retention registers: cleared only by power-on reset
  logic [RETAIN_W-1:0] retain_r [`PMRC_RETAIN_COUNT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < `PMRC_RETAIN_COUNT; i++) begin
        retain_r[i] <= '0;
      end
    end else if (retain_we) begin
      retain_r[retain_idx] <= retain_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    retain_rdata <= retain_r[retain_idx];
  end

  // ==========================================================================
  // Checks
  a_sleep_core_off: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r == pmrc_pkg::ST_SLEEP |-> !gates.core_clk_en) else $error("core clock on in sleep");
  a_sleep_irq_wake: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_r == pmrc_pkg::ST_SLEEP && any_irq && !chip_reset_r) |=> mode_r == pmrc_pkg::ST_RUN)
    else $error("sleep did not wake");
  a_sleep_periph_on: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r == pmrc_pkg::ST_SLEEP |-> (gates.periph_clk_en && gates.irc_run))
    else $error("peripherals stopped in sleep");
  a_deep_gates: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r == pmrc_pkg::ST_DEEPSLEEP |-> (!gates.irc_out_en && gates.flash_standby && !gates.analog_en))
    else $error("deep-sleep gating wrong");
  a_deep_wake_run: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_r == pmrc_pkg::ST_DEEPSLEEP && deep_wake && !chip_reset_r) |=> mode_r == pmrc_pkg::ST_RUN)
    else $error("deep-sleep did not wake");
  a_wake_needs_both: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_r == pmrc_pkg::ST_POWERDOWN && !chip_reset_r && !deep_wake) |=> mode_r == pmrc_pkg::ST_POWERDOWN)
    else $error("power-down left without wake");
  a_pd_flash_off: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r == pmrc_pkg::ST_POWERDOWN |-> (!gates.flash_on && !gates.flash_standby && !gates.irc_run))
    else $error("power-down gating wrong");
  a_dpd_gates_off: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r == pmrc_pkg::ST_DEEPPD |-> (gates == '0))
    else $error("supply left on in deep power-down");
  a_dpd_exit_only: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_r == pmrc_pkg::ST_DEEPPD && !wake_evt && !(wake_pin_timer_en && wake_pin_timer_to))
    |=> mode_r == pmrc_pkg::ST_DEEPPD) else $error("deep power-down left without wake");
  a_dpd_lock: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_r == pmrc_pkg::ST_RUN && sleep_req && mode_sel == `PMRC_MODE_DEEPPD && dpd_lock && !chip_reset_r)
    |=> (mode_r == pmrc_pkg::ST_RUN && dpd_refused)) else $error("locked deep power-down entered");
  a_pin_reset: assert property (@(posedge clk_sys)
    !reset_pin_n ##1 !reset_pin_n |-> ##[2:3] chip_reset) else $error("pin reset missed");
  a_bod_forces_reset: assert property (@(posedge clk_sys) disable iff (reset)
    (bod_rst && bod_rst_en) |=> chip_reset_r) else $error("brownout reset missed");
  a_rst_irc: assert property (@(posedge clk_sys) disable iff (reset)
    chip_reset |=> irc_selected && pll_bypass) else $error("clock not defaulted");
endmodule : power_mode_reset_control
`default_nettype wire

//--- testbench/periph_irq_model.sv
// Partner model: peripherals and interrupt controller facing the block
`default_nettype none
module periph_irq_model (
  input  wire logic                clk_sys,      // System clock
  input  wire logic                reset,        // Sync reset
  input  wire pmrc_pkg::wake_src_s irq_raise,    // Peripheral events
  input  wire pmrc_pkg::wake_src_s wake_en_ctl,  // Controller enables
  output var  pmrc_pkg::wake_src_s wake_int,     // Interrupt lines
  output logic                     any_irq       // Enabled interrupt pending
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered like a peripheral flag, so the block never sees bench edges directly
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_int <= '0;
    end else begin
      wake_int <= irq_raise;
    end
  end
  // Only the controller half of the double enable; the block adds the config half for deep-sleep and power-down wake only
  assign any_irq = |(wake_int & wake_en_ctl);
endmodule : periph_irq_model
`default_nettype wire

//--- testbench/test_power_mode_reset_control.sv
// Self-checking bench for the power-mode and reset control block
`default_nettype none
module test_power_mode_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals and instances
  logic        clk_sys = 1'b0, reset = 1'b1, reset_pin_n = 1'b1, wdt_reset = 1'b0, bod_below_int = 1'b0;
  logic        bod_below_rst = 1'b0, bod_rst_en = 1'b0, sleep_req = 1'b0, dpd_lock = 1'b0, keep_watchdog_oscillator = 1'b0;
  logic        keep_bod = 1'b0, wake_pin_timer_en = 1'b0, wake_pin_timer_to = 1'b0, wake_pin_n = 1'b1;
  logic        clk_sel_write = 1'b0, pll_enable = 1'b0, retain_we = 1'b0, any_irq, chip_reset, flash_init;
  logic        irc_selected, pll_on, pll_bypass, bod_irq, bod_status, dpd_refused;
  logic [1:0]  mode_sel = 2'h0, retain_idx = 2'h0;
  logic [31:0] retain_wdata = 32'h0, retain_rdata, fetch_addr, rnd;
  logic [31:0] ret_m [4];
  int          failures = 0, comparisons = 0, exp_mode = 0, fi_cnt = 0, fi = 0, seed = 32'h4073E028;
  pmrc_pkg::wake_src_s   irq_raise = '0, wake_en_cfg = '0, wake_en_ctl = '0, wake_int;
  pmrc_pkg::power_gate_s gates;
  pmrc_pkg::pmode_e      mode_state;
  power_mode_reset_control power_mode_reset_control_i (
    .clk_sys, .reset, .reset_pin_n, .wdt_reset, .bod_below_int, .bod_below_rst, .bod_rst_en, .sleep_req,
    .mode_sel, .dpd_lock, .keep_watchdog_oscillator, .keep_bod, .wake_pin_timer_en, .wake_pin_timer_to, .wake_pin_n, .any_irq,
    .wake_int, .wake_en_cfg, .wake_en_ctl, .clk_sel_write, .pll_enable, .retain_we, .retain_idx, .retain_wdata,
    .retain_rdata, .gates, .mode_state, .chip_reset, .flash_init, .fetch_addr, .irc_selected, .pll_on,
    .pll_bypass, .bod_irq, .bod_status, .dpd_refused);
  periph_irq_model periph_irq_model_i (.clk_sys, .reset, .irq_raise, .wake_en_ctl, .wake_int, .any_irq);
  always #12.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (flash_init === 1'b1) fi_cnt++;
  // ==========================================
  // Checks and drivers
  task automatic fail(string msg);
    failures++;
    $display("ERROR %0t %s", $time, msg);
  endtask : fail
  task automatic check_val(logic [31:0] got, logic [31:0] exp, string what);
    comparisons++;
    if (got !== exp) fail(what);
  endtask : check_val
  task automatic check_mode();
    comparisons++;
    if (mode_state !== pmrc_pkg::pmode_e'(exp_mode)) fail("mode");
  endtask : check_mode
  // Only fields that the mode pins down are compared; the rest are left to the designer
  task automatic check_gates();
    logic [10:0] e, m;
    case (exp_mode)
      0: begin m = 11'h703; e = 11'h701; end
      1: begin m = 11'h601; e = 11'h201; end
      2: begin m = 11'h7FB; e = 11'h103; end
      3: begin m = 11'h7FF; e = 11'h001; end
      default: begin m = 11'h7FF; e = 11'h000; end
    endcase
    if (exp_mode inside {2, 3}) e[5:4] = {keep_watchdog_oscillator, keep_bod};
    comparisons++;
    if ((gates & m) !== e) fail("gates");
  endtask : check_gates
  task automatic enter(int sel);
    @(posedge clk_sys);
    sleep_req <= 1'b1;
    mode_sel  <= sel[1:0];
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    if (!(sel == 3 && dpd_lock)) exp_mode = sel + 1;
    @(negedge clk_sys);
    check_mode();
    check_gates();
  endtask : enter
  task automatic hold(int n);
    repeat (n) begin
      @(negedge clk_sys);
      check_mode();
    end
  endtask : hold
  task automatic wait_run(int bound);
    int n = 0;
    exp_mode = 0;
    while (mode_state !== pmrc_pkg::ST_RUN && n < bound) begin
      @(negedge clk_sys);
      n++;
    end
    check_mode();
  endtask : wait_run
  task automatic wait_rst(logic v);
    int n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (chip_reset !== v && n < 40);
    check_val(chip_reset, v, "chip reset");
  endtask : wait_rst
  task automatic tally_and_finish();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    fail("timeout");
    tally_and_finish();
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (5) @(posedge clk_sys);
    reset       <= 1'b0;
    wake_en_ctl <= '1;
    @(negedge clk_sys);
    check_val({chip_reset, irc_selected, pll_on, pll_bypass}, 4'hD, "reset state");
    wait_rst(0);
    check_val(fetch_addr, 32'h0, "fetch");
    check_gates();
    enter(0);
    hold(3);
    @(posedge clk_sys);
    irq_raise.spi_int <= 1'b1;
    wait_run(5);
    for (int sel = 1; sel < 3; sel++) begin
      for (int b = 0; b < 5; b++) begin
        @(posedge clk_sys);
        rnd = $random(seed);
        irq_raise   <= '0;
        wake_en_cfg <= '0;
        keep_watchdog_oscillator  <= rnd[0];
        keep_bod    <= rnd[1];
        enter(sel);
        @(posedge clk_sys);
        irq_raise <= 5'h10 >> b;
        hold(4);
        @(posedge clk_sys);
        wake_en_cfg <= 5'h10 >> b;
        wait_run(5);
      end
    end
    @(posedge clk_sys);
    irq_raise <= '0;
    dpd_lock  <= 1'b1;
    enter(3);
    check_val(dpd_refused, 1'b1, "refuse pulse");
    hold(3);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      ret_m[i] = $random(seed);
      retain_we    <= 1'b1;
      retain_idx   <= i[1:0];
      retain_wdata <= ret_m[i];
    end
    @(posedge clk_sys);
    retain_we <= 1'b0;
    dpd_lock  <= 1'b0;
    for (int w = 0; w < 2; w++) begin
      enter(3);
      @(posedge clk_sys);
      wake_pin_timer_to <= 1'b1;
      irq_raise       <= '1;
      hold(5);
      @(posedge clk_sys);
      irq_raise <= '0;
      if (w == 0) wake_pin_timer_en <= 1'b1;
      else wake_pin_n <= 1'b0;
      wait_run(6);
      @(posedge clk_sys);
      {wake_pin_timer_en, wake_pin_timer_to, wake_pin_n} <= 3'b001;
      wait_rst(0);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      retain_idx <= i[1:0];
      @(posedge clk_sys);
      @(negedge clk_sys);
      check_val(retain_rdata, ret_m[i], "retention");
    end
    for (int s = 0; s < 3; s++) begin
      @(posedge clk_sys);
      clk_sel_write <= 1'b1;
      pll_enable    <= 1'b1;
      bod_rst_en    <= 1'b1;
      @(posedge clk_sys);
      clk_sel_write <= 1'b0;
      enter(0);
      check_val(irc_selected, 1'b0, "clock select");
      fi = fi_cnt;
      @(posedge clk_sys);
      case (s)
        0: reset_pin_n <= 1'b0;
        1: wdt_reset <= 1'b1;
        default: bod_below_rst <= 1'b1;
      endcase
      // Two cycles low is the shortest pin pulse that must be caught
      repeat (2) @(posedge clk_sys);
      reset_pin_n   <= 1'b1;
      wdt_reset     <= 1'b0;
      bod_below_rst <= 1'b0;
      exp_mode = 0;
      wait_rst(1);
      // Clock defaults and mode follow one edge after chip reset rises
      @(negedge clk_sys);
      check_val({irc_selected, pll_on, pll_bypass}, 3'h5, "clock restart");
      check_mode();
      wait_rst(0);
      check_val(fi_cnt, fi + 1, "flash init");
      check_val(fetch_addr, 32'h0, "fetch");
      @(posedge clk_sys);
      pll_enable <= 1'b0;
    end
    @(posedge clk_sys);
    bod_rst_en    <= 1'b0;
    bod_below_rst <= 1'b1;
    bod_below_int <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check_val({chip_reset, bod_irq, bod_status}, 3'h3, "brownout level");
    @(posedge clk_sys);
    bod_below_rst <= 1'b0;
    bod_below_int <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check_val({bod_irq, bod_status}, 2'h0, "brownout clear");
    // Power-on reset in mid-run while in deep power-down
    enter(3);
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    exp_mode = 0;
    wait_rst(1);
    @(negedge clk_sys);
    check_mode();
    check_val(retain_rdata, 32'h0, "retention cleared");
    wait_rst(0);
    tally_and_finish();
  end
endmodule : test_power_mode_reset_control
`default_nettype wire
